/* File: mspd_drive.sv */
/*
 motor speed pwm drive: a register port, one pwm channel on bridge input a
 and a plain direction level on bridge input b.
 assumes a synchronous register master that never issues read and write
 together, and a bridge that decodes its two inputs combinationally.
*/
// Chosen here: the plain strobed port and the placing of the registers.
// Behaviour
// - new duty taken at period end, or at once while stopped
// - invert flag with enable inverts the output
// - direction low, pwm gives opposite rotation
// - direction high, power on pwm low phase
// - bridge inputs decode to stop or direction
`default_nettype none

module mspd_drive
   import mspd_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_b,
   // register port
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   output logic      [DATA_W-1:0] rdata,
   // motor bridge inputs
   output logic                   bridge_input_a,
   output logic                   bridge_input_b
);

   // software-visible settings
   logic              channel_enable_flag;   // runs the period counter
   logic              polarity_invert_flag;  // flips the waveform when enabled
   logic [DUTY_W-1:0] range;                 // clocks per period
   logic [DUTY_W-1:0] duty_pending;          // waits for the next pickup
   logic              direction;             // level for bridge input b

   // period state from the counter
   logic [DUTY_W-1:0] cnt;
   logic [DUTY_W-1:0] duty_active;
   logic              wrap;

   // combinational next values
   logic              next_input_a;
   logic [DATA_W-1:0] next_rdata;

   // counter and duty pickup
   mspd_period u_period (
      .clk          (clk),
      .rst_b        (rst_b),
      .run          (channel_enable_flag),
      .range        (range),
      .duty_pending (duty_pending),
      .cnt          (cnt),
      .duty_active  (duty_active),
      .wrap         (wrap)
   );

   // control flags; both clear at reset so nothing pulses before setup
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         channel_enable_flag  <= 1'b0;
         polarity_invert_flag <= 1'b0;
      end else if (wr && addr == OFS_CTRL) begin
         channel_enable_flag  <= wdata[CTRL_EN_BIT];
         polarity_invert_flag <= wdata[CTRL_INV_BIT];
      end
   end

   // range register; wider values are cut, software keeps it at or below 1024
   // a range cut below the running count wraps the counter on the next
   // clock, so software changes it only while the channel is stopped
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         range <= RANGE_RST;
      end else if (wr && addr == OFS_RANGE) begin
         range <= wdata[DUTY_W-1:0];
      end
   end

   // later write replaces
   // the pending value is overwritten by every write; only the one standing
   // at the pickup point ever reaches the output
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         duty_pending <= DUTY_RST;
      end else if (wr && addr == OFS_DUTY) begin
         duty_pending <= wdata[DUTY_W-1:0];
      end
   end

   // direction level; low at reset so the motor stays still during setup
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         direction <= 1'b0;
      end else if (wr && addr == OFS_DIR) begin
         direction <= wdata[0];
      end
   end

   // inverted only when enabled
   // a nonzero duty at or above the range keeps the uninverted output high all period;
   // a disabled channel drives low whatever the invert flag says
   always_comb begin
      next_input_a = 1'b0;
      if (channel_enable_flag) begin
         next_input_a = (cnt < duty_active) ^ polarity_invert_flag;
      end
   end

   // b low, pwm turns opposite way
   // b high, power on low phase
   // both outputs are registered so they change on the same edge
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         bridge_input_a <= 1'b0;
         bridge_input_b <= 1'b0;
      end else begin
         bridge_input_a <= next_input_a;
         bridge_input_b <= direction;
      end
   end

   // read mux; unmapped offsets read as zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (addr)
         OFS_CTRL: begin
            next_rdata[CTRL_EN_BIT]  = channel_enable_flag;
            next_rdata[CTRL_INV_BIT] = polarity_invert_flag;
         end
         OFS_RANGE: begin
            next_rdata[DUTY_W-1:0] = range;
         end
         OFS_DUTY: begin
            next_rdata[DUTY_W-1:0] = duty_pending;
         end
         OFS_DIR: begin
            next_rdata[0] = direction;
         end
         OFS_STATUS: begin
            next_rdata[STAT_DUTY_LSB +: DUTY_W] = duty_active;
            next_rdata[STAT_CNT_LSB +: DUTY_W]  = cnt;
            next_rdata[STAT_OUT_BIT]            = bridge_input_a;
         end
         default: begin
            next_rdata = 32'h0000_0000;
         end
      endcase
   end

   // read data stands only in the cycle after the strobe, zero otherwise
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         rdata <= 32'h0000_0000;
      end else if (rd) begin
         rdata <= next_rdata;
      end else begin
         rdata <= 32'h0000_0000;
      end
   end

   // checks on the outputs and the register port
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   chk_out_compare: assert property (
      (channel_enable_flag && !polarity_invert_flag) |=> (bridge_input_a == ($past(cnt) < $past(duty_active))))
      else $error("pwm output does not follow duty compare");
   chk_invert_out: assert property (
      (channel_enable_flag && polarity_invert_flag) |=> (bridge_input_a != ($past(cnt) < $past(duty_active))))
      else $error("inverted output not inverted");
   chk_disabled_low: assert property (
      !channel_enable_flag |=> !bridge_input_a)
      else $error("output high while channel disabled");
   chk_dir_follow: assert property (
      (wr && addr == OFS_DIR) |=> ##1 (bridge_input_b == $past(wdata[0], 2)))
      else $error("direction output did not follow write");
   chk_dir_level: assert property (
      bridge_input_b == $past(direction))
      else $error("bridge input b not the direction level");
   chk_pickup_wrap: assert property (
      (channel_enable_flag && wrap) |=> (duty_active == $past(duty_pending)))
      else $error("pending duty not picked up at period end");
   chk_read_once: assert property (
      !$past(rd) |-> (rdata == 32'h0000_0000))
      else $error("read data outside its cycle");
   chk_full_duty: assert property (
      (channel_enable_flag && !polarity_invert_flag && duty_active >= range && range != 11'h000)
      |=> bridge_input_a)
      else $error("full duty did not hold output high");
   // readback shows the state of the strobe cycle, one clock behind the pin
   chk_status_out: assert property (
      ($past(rd) && $past(addr) == OFS_STATUS) |-> (rdata[STAT_OUT_BIT] == $past(bridge_input_a)))
      else $error("status output bit differs from the pin");
   chk_ctrl_readback: assert property (
      ($past(rd) && $past(addr) == OFS_CTRL) |-> (rdata[CTRL_INV_BIT] == $past(polarity_invert_flag)))
      else $error("invert flag readback wrong");

   // scenarios: both directions, a replaced duty and a full duty period
   cov_forward: cover property (
      bridge_input_b && polarity_invert_flag && channel_enable_flag ##1 $rose(bridge_input_a));
   cov_reverse: cover property (
      !bridge_input_b && channel_enable_flag ##1 $fell(bridge_input_a));
   cov_replace: cover property (
      (wr && addr == OFS_DUTY) ##1 (wr && addr == OFS_DUTY) ##1 wrap);
   cov_full_duty: cover property (
      channel_enable_flag && !polarity_invert_flag && duty_active == range ##1 bridge_input_a);

endmodule // mspd_drive

`default_nettype wire

/* File: mspd_pkg.sv */
/*
 package for the motor speed pwm drive: register offsets, field positions,
 reset values and widths shared by the drive and its period counter.
 assumes a byte-addressed register port with 32-bit data words.
*/
`default_nettype none

package mspd_pkg;
   // bus widths
   localparam int          ADDR_W        = 8;
   localparam int          DATA_W        = 32;
   // duty and range width; 11 bits so that 1024 itself fits
   localparam int          DUTY_W        = 11;

   // register byte offsets
   localparam logic [7:0]  OFS_CTRL      = 8'h00;   // enable and invert flags
   localparam logic [7:0]  OFS_RANGE     = 8'h04;   // period length in clocks
   localparam logic [7:0]  OFS_DUTY      = 8'h08;   // pending duty value
   localparam logic [7:0]  OFS_DIR       = 8'h0C;   // direction output level
   localparam logic [7:0]  OFS_STATUS    = 8'h10;   // live state, read only

   // control field positions
   localparam int          CTRL_EN_BIT   = 0;
   localparam int          CTRL_INV_BIT  = 1;
   // status field positions
   localparam int          STAT_DUTY_LSB = 0;
   localparam int          STAT_CNT_LSB  = 16;
   localparam int          STAT_OUT_BIT  = 31;

   // reset values
   localparam logic [10:0] RANGE_RST     = 11'h400;   // 1024 clocks per period
   localparam logic [10:0] DUTY_RST      = 11'h000;
endpackage : mspd_pkg

`default_nettype wire

/* File: mspd_period.sv */
/*
 period counter and duty pickup of the motor speed pwm drive.
 assumes run, range and the pending duty come from registers in the
 same clock domain; nothing here faces a pin directly.
*/
`default_nettype none

module mspd_period
   import mspd_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_b,
   // settings
   input  wire logic              run,
   input  wire logic [DUTY_W-1:0] range,
   input  wire logic [DUTY_W-1:0] duty_pending,
   // state
   output logic      [DUTY_W-1:0] cnt,
   output logic      [DUTY_W-1:0] duty_active,
   output logic                   wrap
);

   logic [DUTY_W:0] cnt_plus;   // one wider so the compare with range is exact

   // last clock of the period; a range of zero or one wraps every clock
   always_comb begin
      cnt_plus = {1'b0, cnt} + {{DUTY_W{1'b0}}, 1'b1};
      wrap     = (cnt_plus >= {1'b0, range});
   end

   // counter holds at zero while stopped so a restart begins a full period
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         cnt <= '0;
      end else if (!run || wrap) begin
         cnt <= '0;
      end else begin
         cnt <= cnt_plus[DUTY_W-1:0];
      end
   end

   // pickup at period end
   // a value written mid period waits; a later write simply replaces it.
   // while stopped the new value is taken at once, which the forced update uses
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         duty_active <= DUTY_RST;
      end else if (!run || wrap) begin
         duty_active <= duty_pending;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   chk_duty_hold: assert property (
      (run && !wrap) |=> $stable(duty_active))
      else $error("active duty changed inside a period");
   chk_counter_step: assert property (
      (run && !wrap) |=> (cnt == $past(cnt) + 11'h001))
      else $error("period counter did not advance");
   // a range cut below the running count is only reached after the next wrap
   chk_counter_limit: assert property (
      (range != 11'h000 && $stable(range)) |-> (cnt < range))
      else $error("period counter reached the range");

endmodule // mspd_period

`default_nettype wire

/* File: mspd_bridge_model.sv */
/*
 bridge model: decodes the two bridge inputs into motor motion.
 assumes plain levels from the drive; it has no timing of its own.
*/
`default_nettype none

module mspd_bridge_model (
   // bridge inputs
   input  wire logic       bridge_input_a,
   input  wire logic       bridge_input_b,
   // motion: 0 still, 1 one way, 2 opposite
   output logic      [1:0] motion
);
   timeunit 1ns;
   timeprecision 1ps;

   always_comb begin
      if (bridge_input_a == bridge_input_b) begin
         motion = 2'h0;   // equal levels: no power
      end else if (bridge_input_b) begin
         motion = 2'h1;
      end else begin
         motion = 2'h2;
      end
   end
endmodule // mspd_bridge_model

`default_nettype wire

/* File: mspd_drive_tb.sv */
/*
 self-checking bench for the pwm drive with a bridge model.
 assumes the one-cycle register port of the drive and a 40 MHz clock.
*/
`default_nettype none

module mspd_drive_tb
   import mspd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic              clk, rst_b, wr, rd;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata;
   logic              bridge_input_a, bridge_input_b;
   logic [1:0]        motion;     // decoded by the bridge model
   int                n_fail, num_checks, cyc;
   int                m_range;    // model copy of the period length

   mspd_drive DUT (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata), .bridge_input_a(bridge_input_a), .bridge_input_b(bridge_input_b));
   mspd_bridge_model u_bridge (.bridge_input_a(bridge_input_a), .bridge_input_b(bridge_input_b),
      .motion(motion));

   // 25 ns clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // hang guard, well above the expected run length
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // one-cycle write; a gap cycle keeps the strobe single-driven per step
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      d = rdata;
   endtask

   task automatic chk_reg(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk_cnt(input string n, input int e, input int g);
      num_checks++;
      if (g != e) begin
         n_fail++;
         $display("[FAIL] %s expected %0d seen %0d", n, e, g);
      end
   endtask

   // counts high and powered cycles over a window
   task automatic measure(input int n, output int hi, output int fw, output int rv);
      hi = 0;
      fw = 0;
      rv = 0;
      repeat (n) begin
         @(negedge clk);
         hi += (bridge_input_a === 1'b1);
         fw += (motion === 2'h1);
         rv += (motion === 2'h2);
      end
   endtask

   // forced update, then one full period measured in steady state
   task automatic run_pwm(input int d, input bit inv);
      int hi, fw, rv, eh;
      wr_reg(OFS_CTRL, 32'h0000_0000);
      wr_reg(OFS_DIR, {31'h0, inv});
      wr_reg(OFS_DUTY, 32'(d));
      wr_reg(OFS_CTRL, {30'h0, inv, 1'b1});
      repeat (2 * m_range) @(posedge clk);
      measure(m_range, hi, fw, rv);
      eh = (d > m_range) ? m_range : d;
      if (inv) eh = m_range - eh;
      chk_cnt("high time", eh, hi);
      chk_cnt("forward power", inv ? m_range - eh : 0, fw);
      chk_cnt("reverse power", inv ? 0 : eh, rv);
      $display("test pwm duty %0d invert %0d done", d, inv);
   endtask

   initial begin
      logic [7:0]  ra [5];
      logic [31:0] re [5];
      int          duty [4];
      logic [31:0] d;
      int          hi, fw, rv;
      ra = '{OFS_CTRL, OFS_RANGE, OFS_DUTY, OFS_DIR, 8'h14};
      re = '{32'h0000_0000, 32'h0000_0400, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
      rst_b = 1'b0;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 32'h0000_0000;
      void'($urandom(32'hbce1));
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      // reset values, unmapped address reads zero
      foreach (ra[i]) begin
         rd_reg(ra[i], d);
         chk_reg("reset value", re[i], d);
      end
      measure(8, hi, fw, rv);
      chk_cnt("idle output", 0, hi + fw + rv);
      wr_reg(OFS_RANGE, 32'h0000_0400);
      m_range = 1024;
      run_pwm($urandom_range(1024, 0), 1'b0);
      wr_reg(OFS_CTRL, 32'h0000_0000);
      // bits above the field are dropped
      wr_reg(OFS_RANGE, 32'hFFFF_F810);
      m_range = 16;
      rd_reg(OFS_RANGE, d);
      chk_reg("range", 32'h0000_0010, d);
      $display("test registers done");
      duty = '{0, 16, 4, $urandom_range(15, 1)};
      foreach (duty[i]) begin
         run_pwm(duty[i], 1'b0);
         run_pwm(duty[i], 1'b1);
      end
      // invert without enable keeps the pin low
      wr_reg(OFS_CTRL, 32'h0000_0002);
      wr_reg(OFS_DIR, 32'h0000_0000);
      repeat (4) @(posedge clk);
      measure(m_range, hi, fw, rv);
      chk_cnt("disabled invert", 0, hi);
      $display("test disabled invert done");
      // second write before the wrap replaces the first
      wr_reg(OFS_RANGE, 32'h0000_0040);
      wr_reg(OFS_CTRL, 32'h0000_0000);
      wr_reg(OFS_DUTY, 32'h0000_0005);
      wr_reg(OFS_CTRL, 32'h0000_0001);
      wr_reg(OFS_DUTY, 32'h0000_0009);
      wr_reg(OFS_DUTY, 32'h0000_000C);
      rd_reg(OFS_STATUS, d);
      chk_reg("active duty", 32'h0000_0005, {21'h0, d[10:0]});
      chk_reg("status count out", 32'h8005_0000, {d[31:16], 16'h0000});
      repeat (70) @(posedge clk);
      rd_reg(OFS_STATUS, d);
      chk_reg("active duty", 32'h0000_000C, {21'h0, d[10:0]});
      $display("test pickup done");
      end_of_test();
   end
endmodule // mspd_drive_tb

`default_nettype wire
